// ===== vtadc_pkg.sv
// constants, register map and field layout for the v/t converter control block
// assumes a 10 MHz system clock and a 512 kHz modulator timebase
package vtadc_pkg;
  // register byte addresses
  localparam logic [31:0] VTADC_VT_CTRL_ADDR = 32'hFFFF0510;
  localparam logic [31:0] VTADC_FILT_ADDR = 32'hFFFF0518;
  localparam logic [31:0] VTADC_STATUS_ADDR = 32'hFFFF0520;
  // reset values
  localparam logic [15:0] VTADC_VT_CTRL_RST = 16'h0000;
  localparam logic [15:0] VTADC_FILT_RST = 16'h0007;
  // vt_channel_control fields
  localparam int VTADC_VT_EN_BIT = 15;
  localparam int VTADC_EXC_HI = 14;
  localparam int VTADC_EXC_LO = 13;
  localparam int VTADC_CODING_BIT = 9;
  localparam int VTADC_ZERO_BIT = 8;
  localparam int VTADC_INSEL_HI = 7;
  localparam int VTADC_INSEL_LO = 6;
  localparam int VTADC_REF_HI = 5;
  localparam int VTADC_REF_LO = 4;
  // converter_filter_config fields
  localparam int VTADC_CHOP_BIT = 15;
  localparam int VTADC_RAVG_BIT = 14;
  localparam int VTADC_AF_HI = 13;
  localparam int VTADC_AF_LO = 8;
  localparam int VTADC_NOTCH_BIT = 7;
  localparam int VTADC_SF_HI = 6;
  localparam int VTADC_SF_LO = 0;
  // status fields
  localparam int VTADC_ST_SETTLED_BIT = 0;
  localparam int VTADC_ST_BUSY_BIT = 1;
  localparam int VTADC_ST_COMBO_BIT = 2;
  // input select codes
  localparam logic [1:0] VTADC_IN_BATTERY = 2'h0;
  localparam logic [1:0] VTADC_IN_EXT_TEMP = 2'h1;
  localparam logic [1:0] VTADC_IN_INT_TEMP = 2'h2;
  localparam logic [1:0] VTADC_IN_SHORT = 2'h3;
  // reference select codes
  localparam logic [1:0] VTADC_REF_INTERNAL = 2'h0;
  localparam logic [1:0] VTADC_REF_EXTERNAL = 2'h1;
  localparam logic [1:0] VTADC_REF_EXT_HALF = 2'h2;
  localparam logic [1:0] VTADC_REF_SUPPLY_HALF = 2'h3;
  // timing
  localparam int VTADC_CLK_PERIOD_NS = 100;
  localparam int VTADC_SYS_KHZ = 1000000 / VTADC_CLK_PERIOD_NS;
  localparam int VTADC_MOD_RATE_HZ = 512000;
  localparam int VTADC_MOD_KHZ = VTADC_MOD_RATE_HZ / 1000;
  localparam int VTADC_SINC_OSR = 64;
  localparam int VTADC_AF_OFFSET = 3;
  localparam int VTADC_CHOP_EXTRA = 3;
  localparam logic [6:0] VTADC_SF_60HZ = 7'h7E;
  localparam logic [6:0] VTADC_SF_50HZ = 7'h7F;
  localparam int VTADC_RATE60_HZ = 60;
  localparam int VTADC_RATE50_HZ = 50;
  localparam int VTADC_PERIOD_W = 20;
  // output periods before the first valid result
  localparam logic [2:0] VTADC_SETTLE_PLAIN = 3'h3;
  localparam logic [2:0] VTADC_SETTLE_RAVG = 3'h4;
  localparam logic [2:0] VTADC_SETTLE_AF = 3'h1;
  localparam logic [2:0] VTADC_SETTLE_AF_RAVG = 3'h2;
  localparam logic [2:0] VTADC_SETTLE_CHOP = 3'h2;
  // sf/af combination limits of the filter data path
  localparam logic [6:0] VTADC_SF_LIMIT_MID = 7'h20;
  localparam logic [6:0] VTADC_SF_LIMIT_HIGH = 7'h40;
  localparam logic [5:0] VTADC_AF_LIMIT_MID = 6'h08;
endpackage

// ===== vtadc_mod_tick.sv
// modulator timebase: fractional divider from the system clock
// assumes sys_khz >= mod_khz; one-cycle tick pulses, evenly spread
`timescale 1ns/1ps
module vtadc_mod_tick #(
  parameter int SYS_KHZ = 10000,
  parameter int MOD_KHZ = 512,
  parameter int ACC_W = 15
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  initial begin
    if (MOD_KHZ < 1 || MOD_KHZ > SYS_KHZ || SYS_KHZ >= (1 << (ACC_W - 1))) begin
      $error("vtadc_mod_tick: unusable rate or accumulator width");
    end
  end
  localparam logic [ACC_W-1:0] STEP = ACC_W'(MOD_KHZ);
  localparam logic [ACC_W-1:0] WRAP = ACC_W'(SYS_KHZ);
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_sum;
  assign acc_sum = acc_reg + STEP;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      tick <= 1'b0;
    end else if (acc_sum >= WRAP) begin
      acc_reg <= acc_sum - WRAP;
      tick <= 1'b1;
    end else begin
      acc_reg <= acc_sum;
      tick <= 1'b0;
    end
  end
endmodule // vtadc_mod_tick

// ===== vtadc_period_ctr.sv
// conversion sequencer: counts modulator ticks into output periods
// assumes period_len >= 1 and settle_periods >= 1; restart is a pulse
`timescale 1ns/1ps
module vtadc_period_ctr #(
  parameter int PERIOD_W = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic enable,
  input wire logic restart,
  input wire logic [PERIOD_W-1:0] period_len,
  input wire logic [2:0] settle_periods,
  output logic strobe,
  output logic settled,
  output logic busy
);
  initial begin
    if (PERIOD_W < 8) begin
      $error("vtadc_period_ctr: period width too small");
    end
  end
  logic [PERIOD_W-1:0] cnt_reg;
  logic [2:0] done_reg;
  logic period_end;
  // >= guards against a shorter length arriving mid period
  assign period_end = tick && (cnt_reg >= period_len - PERIOD_W'(1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (restart || !enable) begin
      cnt_reg <= '0; // RL16
    end else if (period_end) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= cnt_reg + PERIOD_W'(1);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= '0;
      settled <= 1'b0;
    end else if (restart || !enable) begin
      done_reg <= '0; // RL16
      settled <= 1'b0;
    end else if (period_end && !settled) begin
      if (done_reg >= settle_periods - 3'h1) begin
        settled <= 1'b1;
      end else begin
        done_reg <= done_reg + 3'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe <= 1'b0;
      busy <= 1'b0;
    end else begin
      // no result until the settling periods have run out
      strobe <= enable && !restart && period_end &&
                (settled || done_reg >= settle_periods - 3'h1); // RL16
      busy <= enable && !restart;
    end
  end
endmodule // vtadc_period_ctr

// ===== vtadc_top.sv
// v/t converter channel control and shared filter configuration, apb slave
// assumes an apb master on CLK_SYS; analog blocks act on the level outputs
`timescale 1ns/1ps
// Operation
// (RL1) bit 15 of channel control powers the v/t converter up; clear powers down
// (RL2) bits 14:13 drive 50 uA sources: none, ext temp, switched ground, both
// (RL3) bit 9 one gives unipolar coding, zero gives two's complement
// (RL4) bits 7:6 select battery/24, ext temp pins, internal sensor, short
// (RL5) temperature inputs route each result to the temperature result register
// (RL6) battery input selection enables the high-voltage buffers automatically; here only while bit 15 is set
// (RL7) bits 5:4 pick reference; supply-half uses switched ground for temperature
// (RL8) software keeps reserved bits 12:10 and 3:0, writes zero to bit 8
// (RL9) any modifying write of filter config resets both converters
// (RL10) bit 15 chops; af zero cuts rate by three; settling two periods
// (RL11) bit 14 runs average of two; forced on under chop; one more period
// (RL12) bits 13:8 hold the averaging factor of the post-filter
// (RL13) bit 7 adds a second notch at 1.333 times the first
// (RL14) bits 6:0 decimation; rate 512000 over (sf+1)*64 up to 125
// (RL15) decimation 126 forces 60 Hz, 127 forces 50 Hz
// (RL16) after filter reset decimation restarts empty; no result until settled
module vtadc_top
  import vtadc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic VT_ENABLE,
  output logic EXT_TEMP_PIN_SRC,
  output logic SWITCHED_GROUND_PIN_SRC,
  output logic VT_UNIPOLAR,
  output logic [1:0] VT_INPUT_SEL,
  output logic HV_BUFFER_EN,
  output logic [1:0] VT_REF_SEL,
  output logic VT_REF_USE_SWITCHED_GROUND,
  output logic CHOP_EN,
  output logic RUN_AVG_EN,
  output logic [5:0] AVERAGING_FACTOR,
  output logic SECOND_NOTCH_EN,
  output logic [6:0] DECIMATION_FACTOR,
  output logic I_CONV_RESET,
  output logic VT_CONV_RESET,
  output logic VT_RESULT_STROBE,
  output logic VT_RESULT_TO_TEMP
);
  localparam int PW = VTADC_PERIOD_W;
  localparam logic [PW-1:0] LEN_60HZ = PW'(VTADC_MOD_RATE_HZ / VTADC_RATE60_HZ);
  localparam logic [PW-1:0] LEN_50HZ = PW'(VTADC_MOD_RATE_HZ / VTADC_RATE50_HZ);
  localparam logic [PW-1:0] OSR = PW'(VTADC_SINC_OSR);
  localparam logic [PW-1:0] AF_OFS = PW'(VTADC_AF_OFFSET);
  localparam logic [PW-1:0] CHOP_ADD = PW'(VTADC_CHOP_EXTRA);
  // longest chopped period at full factors must fit the period counter
  localparam int MAX_LEN = (int'(VTADC_SF_50HZ) + 1) * VTADC_SINC_OSR *
    (int'(6'h3F) + VTADC_AF_OFFSET) + VTADC_CHOP_EXTRA;

  initial begin
    if (MAX_LEN >= (1 << PW)) begin
      $error("vtadc_top: period counter too narrow");
    end
  end

  logic [15:0] vt_ctrl_reg;
  logic [15:0] filt_reg;
  logic [15:0] wdata16;
  logic sel_vt;
  logic sel_filt;
  logic sel_status;
  logic setup_phase;
  logic access_done;
  logic wr_vt;
  logic wr_filt;
  logic filt_changed;
  logic conv_reset_reg;
  logic [15:0] status_word;
  logic mod_tick;
  logic seq_strobe;
  logic seq_settled;
  logic seq_busy;
  logic combo_bad;
  logic chop;
  logic ravg_eff;
  logic [5:0] af;
  logic [6:0] sf;
  logic [1:0] in_sel;
  logic [PW-1:0] base_len;
  logic [PW-1:0] period_len;
  logic [2:0] settle_periods;

  // ---------------- apb slave ----------------
  assign wdata16 = PWDATA[15:0];
  assign sel_vt = (PADDR == VTADC_VT_CTRL_ADDR);
  assign sel_filt = (PADDR == VTADC_FILT_ADDR);
  assign sel_status = (PADDR == VTADC_STATUS_ADDR);
  assign setup_phase = PSEL && !PENABLE;
  // PREADY is registered, so every access has exactly one access cycle
  assign access_done = PSEL && PENABLE && PREADY;
  assign wr_vt = access_done && PWRITE && sel_vt;
  assign wr_filt = access_done && PWRITE && sel_filt;
  assign filt_changed = wr_filt && (wdata16 != filt_reg);

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup_phase;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PSLVERR <= 1'b0;
    end else if (setup_phase) begin
      PSLVERR <= !(sel_vt || sel_filt || sel_status);
    end else if (access_done) begin
      PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h00000000;
    end else if (setup_phase && !PWRITE) begin
      if (sel_vt) begin
        PRDATA <= {16'h0000, vt_ctrl_reg};
      end else if (sel_filt) begin
        PRDATA <= {16'h0000, filt_reg};
      end else if (sel_status) begin
        PRDATA <= {16'h0000, status_word};
      end else begin
        PRDATA <= 32'h00000000;
      end
    end else if (access_done) begin
      PRDATA <= 32'h00000000;
    end
  end

  // ---------------- registers ----------------
  // reserved bits are stored so software can read-modify-write them
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      vt_ctrl_reg <= VTADC_VT_CTRL_RST;
    end else if (wr_vt) begin
      vt_ctrl_reg <= wdata16;
      vt_ctrl_reg[VTADC_ZERO_BIT] <= 1'b0; // RL8
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      filt_reg <= VTADC_FILT_RST;
    end else if (wr_filt) begin
      filt_reg <= wdata16;
    end
  end

  // a rewrite of the same value leaves running conversions alone
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      conv_reset_reg <= 1'b0;
    end else begin
      conv_reset_reg <= filt_changed; // RL9
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      I_CONV_RESET <= 1'b0;
      VT_CONV_RESET <= 1'b0;
    end else begin
      I_CONV_RESET <= filt_changed; // RL9
      VT_CONV_RESET <= filt_changed; // RL9
    end
  end

  // ---------------- channel control outputs ----------------
  assign in_sel = vt_ctrl_reg[VTADC_INSEL_HI:VTADC_INSEL_LO];

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      VT_ENABLE <= 1'b0;
      EXT_TEMP_PIN_SRC <= 1'b0;
      SWITCHED_GROUND_PIN_SRC <= 1'b0;
      VT_UNIPOLAR <= 1'b0;
    end else begin
      VT_ENABLE <= vt_ctrl_reg[VTADC_VT_EN_BIT]; // RL1
      EXT_TEMP_PIN_SRC <= vt_ctrl_reg[VTADC_EXC_LO]; // RL2
      SWITCHED_GROUND_PIN_SRC <= vt_ctrl_reg[VTADC_EXC_HI]; // RL2
      VT_UNIPOLAR <= vt_ctrl_reg[VTADC_CODING_BIT]; // RL3
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      VT_INPUT_SEL <= VTADC_IN_BATTERY;
      HV_BUFFER_EN <= 1'b0;
    end else begin
      VT_INPUT_SEL <= in_sel; // RL4
      // buffers only matter while the converter is powered
      HV_BUFFER_EN <= vt_ctrl_reg[VTADC_VT_EN_BIT] && (in_sel == VTADC_IN_BATTERY); // RL6
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      VT_REF_SEL <= VTADC_REF_INTERNAL;
      VT_REF_USE_SWITCHED_GROUND <= 1'b0;
    end else begin
      VT_REF_SEL <= vt_ctrl_reg[VTADC_REF_HI:VTADC_REF_LO]; // RL7
      VT_REF_USE_SWITCHED_GROUND <=
        (vt_ctrl_reg[VTADC_REF_HI:VTADC_REF_LO] == VTADC_REF_SUPPLY_HALF) &&
        (in_sel == VTADC_IN_EXT_TEMP || in_sel == VTADC_IN_INT_TEMP); // RL7
    end
  end

  // ---------------- filter configuration outputs ----------------
  assign chop = filt_reg[VTADC_CHOP_BIT];
  assign ravg_eff = filt_reg[VTADC_RAVG_BIT] || chop; // RL11
  assign af = filt_reg[VTADC_AF_HI:VTADC_AF_LO];
  assign sf = filt_reg[VTADC_SF_HI:VTADC_SF_LO];

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      CHOP_EN <= 1'b0;
      RUN_AVG_EN <= 1'b0;
      AVERAGING_FACTOR <= VTADC_FILT_RST[VTADC_AF_HI:VTADC_AF_LO];
      SECOND_NOTCH_EN <= 1'b0;
      DECIMATION_FACTOR <= VTADC_FILT_RST[VTADC_SF_HI:VTADC_SF_LO];
    end else begin
      CHOP_EN <= chop; // RL10
      RUN_AVG_EN <= ravg_eff; // RL11
      AVERAGING_FACTOR <= af; // RL12
      SECOND_NOTCH_EN <= filt_reg[VTADC_NOTCH_BIT]; // RL13
      DECIMATION_FACTOR <= sf; // RL14
    end
  end

  // ---------------- output period and settling ----------------
  // length in modulator ticks; the forced rates round down to whole ticks
  assign base_len = (PW'(sf) + PW'(1)) * OSR;

  always_comb begin
    period_len = base_len; // RL14
    if (sf == VTADC_SF_60HZ) begin
      period_len = LEN_60HZ; // RL15
    end else if (sf == VTADC_SF_50HZ) begin
      period_len = LEN_50HZ; // RL15
    end else if (chop) begin
      period_len = base_len * (PW'(af) + AF_OFS) + CHOP_ADD; // RL10
    end else if (af != 6'h00) begin
      period_len = base_len * (PW'(af) + AF_OFS); // RL12
    end
  end

  always_comb begin
    settle_periods = VTADC_SETTLE_PLAIN;
    if (chop) begin
      settle_periods = VTADC_SETTLE_CHOP; // RL10
    end else if (af != 6'h00) begin
      settle_periods = ravg_eff ? VTADC_SETTLE_AF_RAVG : VTADC_SETTLE_AF; // RL11
    end else if (ravg_eff) begin
      settle_periods = VTADC_SETTLE_RAVG; // RL11
    end
  end

  // the data path cannot serve every sf/af pair; flagged, not blocked
  assign combo_bad = (sf >= VTADC_SF_LIMIT_HIGH && af != 6'h00) ||
                     (sf >= VTADC_SF_LIMIT_MID && af >= VTADC_AF_LIMIT_MID);

  assign status_word = {13'h0000, combo_bad, seq_busy, seq_settled};

  vtadc_mod_tick #(
    .SYS_KHZ(VTADC_SYS_KHZ),
    .MOD_KHZ(VTADC_MOD_KHZ),
    .ACC_W(15)
  ) u_tick (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .tick(mod_tick)
  );

  // every filter reset restarts decimation from an empty state
  vtadc_period_ctr #(
    .PERIOD_W(PW)
  ) u_seq (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .tick(mod_tick),
    .enable(vt_ctrl_reg[VTADC_VT_EN_BIT]),
    .restart(conv_reset_reg), // RL16
    .period_len(period_len),
    .settle_periods(settle_periods),
    .strobe(seq_strobe),
    .settled(seq_settled),
    .busy(seq_busy)
  );

  // a result launched just before a power-down or filter reset is dropped
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      VT_RESULT_STROBE <= 1'b0;
      VT_RESULT_TO_TEMP <= 1'b0;
    end else begin
      VT_RESULT_STROBE <= seq_strobe && vt_ctrl_reg[VTADC_VT_EN_BIT] &&
                          !conv_reset_reg; // RL16
      VT_RESULT_TO_TEMP <= (in_sel == VTADC_IN_EXT_TEMP) ||
                           (in_sel == VTADC_IN_INT_TEMP); // RL5
    end
  end

endmodule // vtadc_top

// ===== vtadc_chk.sv
// concurrent checks on the ports of vtadc_top
// assumes one clock domain, CLK_SYS, with RESET_N asynchronous active low
`timescale 1ns/1ps
module vtadc_chk
  import vtadc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic VT_ENABLE,
  input wire logic [1:0] VT_INPUT_SEL,
  input wire logic HV_BUFFER_EN,
  input wire logic [1:0] VT_REF_SEL,
  input wire logic VT_REF_USE_SWITCHED_GROUND,
  input wire logic CHOP_EN,
  input wire logic RUN_AVG_EN,
  input wire logic [6:0] DECIMATION_FACTOR,
  input wire logic I_CONV_RESET,
  input wire logic VT_CONV_RESET,
  input wire logic VT_RESULT_STROBE,
  input wire logic VT_RESULT_TO_TEMP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  logic filt_wr;
  logic [8:0] since_rst_reg;
  logic [15:0] filt_shadow_reg;
  assign filt_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == VTADC_FILT_ADDR;
  // saturates so a long run never wraps into a false early result
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) since_rst_reg <= 9'h000;
    else if (VT_CONV_RESET) since_rst_reg <= 9'h000;
    else if (since_rst_reg != 9'h1FF) since_rst_reg <= since_rst_reg + 9'h001;
  end
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) filt_shadow_reg <= VTADC_FILT_RST;
    else if (filt_wr) filt_shadow_reg <= PWDATA[15:0];
  end
  a_chop_forces_avg: assert property (CHOP_EN |-> RUN_AVG_EN)
    else $error("running average off while chopping");
  a_battery_hv_buf: assert property (VT_ENABLE && VT_INPUT_SEL == VTADC_IN_BATTERY
    |-> HV_BUFFER_EN)
    else $error("battery input without high-voltage buffers");
  a_temp_result_route: assert property (VT_RESULT_STROBE |-> VT_RESULT_TO_TEMP ==
    (VT_INPUT_SEL == VTADC_IN_EXT_TEMP || VT_INPUT_SEL == VTADC_IN_INT_TEMP))
    else $error("result routed to wrong register");
  a_result_needs_en: assert property (VT_RESULT_STROBE |-> VT_ENABLE)
    else $error("result while converter powered down");
  a_filt_vt_reset: assert property (filt_wr && PWDATA[15:0] != filt_shadow_reg
    |-> ##[0:4] VT_CONV_RESET)
    else $error("filter write without v/t converter reset");
  a_filt_i_reset: assert property (filt_wr && PWDATA[15:0] != filt_shadow_reg
    |-> ##[0:4] I_CONV_RESET)
    else $error("filter write without current converter reset");
  a_no_early_result: assert property (VT_RESULT_STROBE |-> since_rst_reg >= 9'h12C)
    else $error("result too soon after converter reset");
  a_sf_field_update: assert property (filt_wr |-> ##[1:4]
    DECIMATION_FACTOR == filt_shadow_reg[6:0])
    else $error("decimation factor not taken from write");
  a_ref_ground_sel: assert property (VT_REF_USE_SWITCHED_GROUND
    |-> VT_REF_SEL == VTADC_REF_SUPPLY_HALF)
    else $error("switched ground used without supply-half reference");
  c_temp_result: cover property (VT_RESULT_STROBE && VT_RESULT_TO_TEMP);
  c_chop_on: cover property (CHOP_EN);
  c_conv_reset: cover property (filt_wr ##[1:4] VT_CONV_RESET);
endmodule // vtadc_chk

bind vtadc_top vtadc_chk u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .VT_ENABLE(VT_ENABLE), .VT_INPUT_SEL(VT_INPUT_SEL), .HV_BUFFER_EN(HV_BUFFER_EN),
  .VT_REF_SEL(VT_REF_SEL), .VT_REF_USE_SWITCHED_GROUND(VT_REF_USE_SWITCHED_GROUND),
  .CHOP_EN(CHOP_EN), .RUN_AVG_EN(RUN_AVG_EN), .DECIMATION_FACTOR(DECIMATION_FACTOR),
  .I_CONV_RESET(I_CONV_RESET), .VT_CONV_RESET(VT_CONV_RESET),
  .VT_RESULT_STROBE(VT_RESULT_STROBE), .VT_RESULT_TO_TEMP(VT_RESULT_TO_TEMP));

// ===== vtadc_top_tb.sv
// self-checking bench for vtadc_top over apb
// assumes the checker is bound from vtadc_chk.sv; 10 MHz clock
`timescale 1ns/1ps
module vtadc_top_tb;
  import vtadc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, vt_en, ext_src, swg_src, unip, hv, ref_swg, chop, ravg, notch;
  logic [1:0] insel, refsel;
  logic [5:0] af;
  logic [6:0] sf;
  logic i_rst, vt_rst, strobe, to_temp, err;
  int vt_rst_cnt = 0;
  int i_rst_cnt = 0;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (vt_rst === 1'b1) vt_rst_cnt <= vt_rst_cnt + 1;
    if (i_rst === 1'b1) i_rst_cnt <= i_rst_cnt + 1;
  end
  vtadc_top dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .VT_ENABLE(vt_en), .EXT_TEMP_PIN_SRC(ext_src),
    .SWITCHED_GROUND_PIN_SRC(swg_src), .VT_UNIPOLAR(unip), .VT_INPUT_SEL(insel),
    .HV_BUFFER_EN(hv), .VT_REF_SEL(refsel), .VT_REF_USE_SWITCHED_GROUND(ref_swg),
    .CHOP_EN(chop), .RUN_AVG_EN(ravg), .AVERAGING_FACTOR(af), .SECOND_NOTCH_EN(notch),
    .DECIMATION_FACTOR(sf), .I_CONV_RESET(i_rst), .VT_CONV_RESET(vt_rst),
    .VT_RESULT_STROBE(strobe), .VT_RESULT_TO_TEMP(to_temp));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test;
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      stop_test;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_strobe(output int c);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (strobe !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      miscompares++;
      stop_test;
    end
    c = cyc;
  endtask
  task t_reset_values;
    apb(1'b0, VTADC_VT_CTRL_ADDR, 32'h0);
    check("ctrl_reset", q[15:0], VTADC_VT_CTRL_RST);
    check("ctrl_err", err, 1'b0);
    apb(1'b0, VTADC_FILT_ADDR, 32'h0);
    check("filt_reset", q[15:0], VTADC_FILT_RST);
    apb(1'b0, 32'hFFFF0530, 32'h0);
    check("bad_addr_err", err, 1'b1);
    check("bad_addr_data", q, 32'h0);
  endtask
  task t_ctrl_codes;
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, VTADC_VT_CTRL_ADDR, 32'h0);
      // reserved bits kept as read, bit 8 written zero
      v = (q & 32'h00001C0F) | {16'h0, i != 1, 2'(i), 3'h0, i[0], 1'b0, 2'(i), 2'(i + 1), 4'h0};
      apb(1'b1, VTADC_VT_CTRL_ADDR, v);
      repeat (3) @(posedge clk_sys);
      check("ctrl_out", {vt_en, swg_src, ext_src, unip, insel, refsel, hv, ref_swg},
        {v[15:13], v[9], v[7:4], i == 0, i == 2});
      apb(1'b0, VTADC_VT_CTRL_ADDR, 32'h0);
      check("ctrl_read", q[15:0], v[15:0]);
    end
  endtask
  task t_filt_fields;
    logic [15:0] tbl [6];
    int v0, i0;
    // the last entry rewrites the stored value, which is no modification
    tbl = '{16'h8105, 16'h4080, 16'h0A20, 16'h007E, 16'h007F, 16'h007F};
    foreach (tbl[k]) begin
      v0 = vt_rst_cnt;
      i0 = i_rst_cnt;
      apb(1'b1, VTADC_FILT_ADDR, {16'h0, tbl[k]});
      repeat (4) @(posedge clk_sys);
      check("filt_out", {chop, ravg, af, notch, sf},
        {tbl[k][15], tbl[k][15] | tbl[k][14], tbl[k][13:0]});
      check("vt_conv_reset", vt_rst_cnt - v0, k != 5);
      check("i_conv_reset", i_rst_cnt - i0, k != 5);
      apb(1'b0, VTADC_FILT_ADDR, 32'h0);
      check("filt_read", q[15:0], tbl[k]);
      apb(1'b0, VTADC_STATUS_ADDR, 32'h0);
      check("status", q[2:0], {k == 2, 2'h2});
    end
  endtask
  // ticks: modulator ticks per output period; settle: periods before first result
  task automatic t_rate(input logic [15:0] f, input int ticks, input int settle,
    input logic [1:0] in);
    int c0, c1, c2, per;
    per = ticks * VTADC_SYS_KHZ / VTADC_MOD_KHZ;
    apb(1'b1, VTADC_VT_CTRL_ADDR, {16'h0, 1'b1, 7'h0, in, 6'h0});
    apb(1'b1, VTADC_FILT_ADDR, {16'h0, f});
    c0 = cyc;
    wait_strobe(c1);
    check("to_temp", to_temp, in == VTADC_IN_EXT_TEMP || in == VTADC_IN_INT_TEMP);
    wait_strobe(c2);
    check("settle", c1 - c0 >= settle * per - 20 && c1 - c0 <= settle * per + 10,
      1'b1);
    check("period", c2 - c1 >= per - 2 && c2 - c1 <= per + 2, 1'b1);
    apb(1'b0, VTADC_STATUS_ADDR, 32'h0);
    check("settled", q[2:0], 3'h3);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset_values();
    t_ctrl_codes();
    t_filt_fields();
    t_rate(16'h0000, 64, 3, VTADC_IN_BATTERY);
    t_rate(16'h0100, 256, 1, VTADC_IN_INT_TEMP);
    t_rate(16'h8000, 195, 2, VTADC_IN_EXT_TEMP);
    t_rate(16'h4081, 128, 4, VTADC_IN_SHORT);
    stop_test;
  end
endmodule // vtadc_top_tb
